// *** core/tcp_top.sv ***
// Purpose: 8-bit timer/counter with shared prescaler and APB registers
// Assumes: APB3 slave, ref_clk 125 MHz, one instruction cycle = 4 clocks
// Notes: Watchdog tick output carries the prescaled watchdog rate only when the watchdog owns the prescaler with a nonzero rate code
`timescale 1ns/1ps
module tcp_top (
    input wire logic ref_clk,            // 125 MHz core clock
    input wire logic rst,                // Async reset, active high
    input wire logic psel,               // APB select
    input wire logic penable,            // APB enable
    input wire logic pwrite,             // APB write
    input wire logic [7:0] paddr,        // APB byte address
    input wire logic [31:0] pwdata,      // APB write data
    output logic [31:0] prdata,          // APB read data
    output logic pready,                 // APB ready
    output logic pslverr,                // APB error
    input wire logic ext_count_pin,      // External count input
    input wire logic sleep,              // Core is asleep
    input wire logic wdt_osc_tick,       // Watchdog oscillator tick
    output logic wdt_tick,               // Watchdog tick after routing
    output logic irq                     // Level interrupt
);
    import tcp_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Registers and decode
    logic [7:0] counter_value_reg_r;
    logic [7:0] option_r;
    logic [1:0] status_r;
    logic [1:0] mask_r;
    logic [1:0] inhibit_r;
    logic [1:0] cyc_r;
    logic [2:0] presc_tap;
    tcp_opt_t opt;
    logic wr_acc;
    logic rd_acc;
    logic wr_count;
    logic wr_option;
    logic cyc_tick;
    logic pin_edge;
    logic src_tick;
    logic presc_in;
    logic presc_out;
    logic presc_clr;
    logic timer_tick;
    logic inc;
    logic ovf;
    logic src_ok;
    logic [1:0] ev;
    logic [31:0] rd_nxt;
    logic err_nxt;

    assign opt = tcp_opt_t'(option_r[5:0]);
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & ~penable & ~pwrite;
    assign wr_count = wr_acc & (paddr == TCP_OFS_COUNT);
    assign wr_option = wr_acc & (paddr == TCP_OFS_OPTION);

    ////////////////////////////////////////////////////////////////////
    // Instruction cycle strobe; frozen in sleep
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cyc_r <= 2'h0;
        end else if (!sleep) begin
            cyc_r <= cyc_r + 2'h1;
        end
    end
    assign cyc_tick = ~sleep & (cyc_r == 2'(TCP_CYC_DIV - 1));

    // External pin edges, synchronised first
    tcp_edge u_edge (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in(ext_count_pin),
        .fall_sel(opt.edge_sel),
        .edge_pulse(pin_edge)
    );

    // Source select: instruction cycles or pin edges, none in sleep
    assign src_tick = ~sleep & (opt.source_sel ? pin_edge : cyc_tick);

    ////////////////////////////////////////////////////////////////////
    // Shared prescaler: its input follows the assignment bit
    assign presc_in = opt.assign_wdt ? wdt_osc_tick : src_ok;
    // Re-routing, or a counter write while the timer owns the prescaler, restarts the division
    assign presc_clr = wr_option | (wr_count & ~opt.assign_wdt);

    tcp_prescale #(
        .WIDTH(8)
    ) u_presc (
        .ref_clk(ref_clk),
        .rst(rst),
        .clr(presc_clr),
        .in_tick(presc_in),
        .tap(presc_tap),
        .out_tick(presc_out)
    );

    // Timer takes prescaled ticks only when it owns the prescaler
    assign timer_tick = opt.assign_wdt ? src_ok : presc_out;

    // Watchdog ratio is half the timer's: one tap lower, code 000 passes
    assign presc_tap = (opt.assign_wdt && opt.rate != 3'h0) ?
        opt.rate - 3'h1 : opt.rate;

    // Watchdog sees raw ticks unless it owns the prescaler with a nonzero rate code
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wdt_tick <= 1'b0;
        end else if (!opt.assign_wdt || opt.rate == 3'h0) begin
            wdt_tick <= wdt_osc_tick;
        end else begin
            wdt_tick <= presc_out;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Write inhibit: two instruction cycles after a counter write; pin edges
    // falling inside it are lost, as a user must allow for
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            inhibit_r <= 2'h0;
        end else if (wr_count) begin
            inhibit_r <= TCP_WR_INHIBIT;
        end else if (cyc_tick && inhibit_r != 2'h0) begin
            inhibit_r <= inhibit_r - 2'h1;
        end
    end
    // Gate sits ahead of the prescaler so a ratio cannot stretch it
    assign src_ok = src_tick & (inhibit_r == 2'h0);
    assign inc = timer_tick;

    // Counter; software write wins over increment
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            counter_value_reg_r <= TCP_COUNT_RST;
        end else if (wr_count) begin
            counter_value_reg_r <= pwdata[7:0];
        end else if (inc) begin
            counter_value_reg_r <= counter_value_reg_r + 8'h01;
        end
    end
    assign ovf = inc & ~wr_count & (counter_value_reg_r == 8'hFF);

    // Option register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            option_r <= TCP_OPTION_RST;
        end else if (wr_option) begin
            option_r <= {2'h0, pwdata[5:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear; a new event beats the clear
    assign ev[TCP_ST_OVF] = ovf;
    assign ev[TCP_ST_WDT] = wdt_tick;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_r <= 2'h0;
        end else begin
            // Hardware never clears; software must
            if (wr_acc && paddr == TCP_OFS_STATUS) begin
                status_r <= (status_r & ~pwdata[1:0]) | ev;
            end else begin
                status_r <= status_r | ev;
            end
        end
    end

    // Mask register, bit 0 is overflow_irq_enable
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            mask_r <= 2'h0;
        end else if (wr_acc && paddr == TCP_OFS_MASK) begin
            mask_r <= pwdata[1:0];
        end
    end

    // Interrupt masked only; counter keeps running
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB read mux; prescaler count has no address
    always_comb begin
        rd_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        if (paddr == TCP_OFS_COUNT) begin
            rd_nxt = {24'h00_0000, counter_value_reg_r};
        end else if (paddr == TCP_OFS_OPTION) begin
            rd_nxt = {24'h00_0000, option_r};
        end else if (paddr == TCP_OFS_STATUS) begin
            rd_nxt = {30'h0000_0000, status_r};
        end else if (paddr == TCP_OFS_MASK) begin
            rd_nxt = {30'h0000_0000, mask_r};
        end else begin
            err_nxt = 1'b1;
        end
    end

    // Ready in the access cycle; data latched in setup
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & err_nxt;
            if (rd_acc) begin
                prdata <= rd_nxt;
            end
        end
    end
endmodule

// *** core/tcp_pkg.sv ***
// Purpose: Shared constants and types for the timer/counter with prescaler
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Register offsets are byte addresses
package tcp_pkg;
    // Register byte offsets
    localparam logic [7:0] TCP_OFS_COUNT = 8'h00;
    localparam logic [7:0] TCP_OFS_OPTION = 8'h04;
    localparam logic [7:0] TCP_OFS_STATUS = 8'h08;
    localparam logic [7:0] TCP_OFS_MASK = 8'h0C;
    localparam logic [7:0] TCP_OFS_CTRL = 8'h10;
    // Option register field positions
    localparam int TCP_OPT_RATE_LSB = 0;
    localparam int TCP_OPT_ASSIGN = 3;
    localparam int TCP_OPT_EDGE = 4;
    localparam int TCP_OPT_SOURCE = 5;
    // Status and mask bit positions
    localparam int TCP_ST_OVF = 0;
    localparam int TCP_ST_WDT = 1;
    // Control register bit: sleep
    localparam int TCP_CTRL_SLEEP = 0;
    // Reset values
    localparam logic [7:0] TCP_OPTION_RST = 8'hFF;
    localparam logic [7:0] TCP_COUNT_RST = 8'h00;
    // Write-inhibit length after a counter write, instruction cycles
    localparam logic [1:0] TCP_WR_INHIBIT = 2'h2;
    // Instruction cycle is this many clocks
    localparam int TCP_CYC_DIV = 4;

    // Decoded option settings
    typedef struct packed {
        logic source_sel;   // 1 = external pin
        logic edge_sel;     // 1 = falling edge
        logic assign_wdt;   // 1 = prescaler to watchdog
        logic [2:0] rate;   // Rate select code
    } tcp_opt_t;
endpackage

// *** core/tcp_edge.sv ***
// Purpose: Synchronise the external count pin and detect the chosen edge
// Assumes: Pin is asynchronous to ref_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module tcp_edge (
    input wire logic ref_clk,   // Core clock
    input wire logic rst,       // Async reset, active high
    input wire logic pin_in,    // External count pin
    input wire logic fall_sel,  // 1 = falling edge
    output logic edge_pulse     // One-cycle pulse per qualifying edge
);
    logic meta_r;
    logic sync_r;
    logic last_r;

    // Two-flop synchroniser and history
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    // Edge only from synchronised stages
    assign edge_pulse = fall_sel ? (last_r & ~sync_r) : (~last_r & sync_r);
endmodule

// *** core/tcp_prescale.sv ***
// Purpose: Shared 8-bit prescaler with selectable power-of-two tap
// Assumes: in_tick is a one-cycle pulse
// Notes: Count is internal; no path to read or load it
`timescale 1ns/1ps
module tcp_prescale #(
    parameter int WIDTH = 8     // Prescaler width
) (
    input wire logic ref_clk,        // Core clock
    input wire logic rst,            // Async reset, active high
    input wire logic clr,            // Clear count
    input wire logic in_tick,        // Input event
    input wire logic [2:0] tap,      // Bit index 0..7 selects 1:2..1:256
    output logic out_tick            // Divided event pulse
);
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    assign cnt_nxt = cnt_r + 1'b1;

    // Counter; a tap bit falling marks each ratio period
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (clr) begin
            cnt_r <= '0;
        end else if (in_tick) begin
            cnt_r <= cnt_nxt;
        end
    end

    assign out_tick = in_tick & ~clr & cnt_r[tap] & ~cnt_nxt[tap];
endmodule

// *** sim/tcp_sva.sv ***
// Purpose: Port checks for the timer/counter block
// Assumes: Zero-wait APB, registered irq
// Notes: Bound to every tcp_top instance
`timescale 1ns/1ps
module tcp_sva (
    input wire logic ref_clk, // Core clock
    input wire logic rst, // Async reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic sleep, // Core asleep
    input wire logic irq // Interrupt
);
    import tcp_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Handshake: one answer per setup, never unasked
    pready_next_a: assert property (
        psel && !penable |=> pready) else $error("setup not answered");
    pready_cause_a: assert property (
        pready |-> $past(psel && !penable)) else $error("stray ready");
    // Only the mapped words answer cleanly; others read zero
    err_map_a: assert property (
        pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > TCP_OFS_MASK))
        else $error("error flag wrong");
    err_zero_a: assert property (
        pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("error read not zero");
    upper_zero_a: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // Clearing the enable drops irq after its one-cycle lag
    mask_irq_a: assert property (
        pready && pwrite && paddr == TCP_OFS_MASK && pwdata[1:0] == 2'h0
        |-> ##2 !irq) else $error("irq not masked");
    // A fresh count value holds across the blocked ticks
    wr_hold_a: assert property (
        pready && pwrite && paddr == TCP_OFS_COUNT
        ##1 psel && !pwrite && paddr == TCP_OFS_COUNT ##1 pready
        ##1 psel && !pwrite && paddr == TCP_OFS_COUNT ##1 pready
        ##1 psel && !pwrite && paddr == TCP_OFS_COUNT ##1 pready
        |-> prdata[7:0] == $past(pwdata[7:0], 6))
        else $error("write not held");
    sleep_freeze_a: assert property (
        sleep && pready && !pwrite && paddr == TCP_OFS_COUNT
        ##1 sleep && psel
        ##1 sleep && pready && !pwrite && paddr == TCP_OFS_COUNT
        |-> prdata[7:0] == $past(prdata[7:0], 2))
        else $error("count moved in sleep");
endmodule
////////////////////////////////////////////////////////////
bind tcp_top tcp_sva tcp_sva_i (.ref_clk, .rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep, .irq);

// *** sim/tcp_pin_model.sv ***
// Purpose: External source driving the count pin
// Assumes: Push-pull source that holds its level
// Notes: Edges land off the clock grid on purpose
`timescale 1ns/1ps
module tcp_pin_model (
    output logic pin // Count pin level
);
    initial pin = 1'b0;
    // Slow toggles, far above the synchroniser delay
    task automatic toggle(input int n);
        repeat (n) begin
            #61 pin = ~pin;
        end
    endtask
endmodule

// *** sim/tcp_top_tb.sv ***
// Purpose: Self-checking bench for the timer/counter block
// Assumes: Zero-wait APB, instruction cycle of four clocks
// Notes: Masks hide the free tick phase in long counts
`timescale 1ns/1ps
module tcp_top_tb;
    import tcp_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sleep = 1'b0;
    logic wdt_osc_tick = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, wdt_tick, irq, pin;
    logic [63:0] expq[$];
    logic [63:0] note;
    logic [7:0] v;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 32'hf3a8;
    logic [31:0] osc_n = 32'h0;
    logic [31:0] wdt_n = 32'h0;
    logic [31:0] o0;
    logic [31:0] w0;

    always #4 ref_clk = ~ref_clk;
    tcp_top tcp_top_i (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ext_count_pin(pin), .sleep,
        .wdt_osc_tick, .wdt_tick, .irq);
    tcp_pin_model tcp_pin_model_i (.pin);
    ////////////////////////////////////////////////////////////
    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_irq(input logic e);
        compare({31'h0, irq}, {31'h0, e});
    endtask
    task automatic finish_test();
        fail_count += expq.size();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Request held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
        expq.push_back({e & m, m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    // Read checker, plus watchdog noise and the hang limit
    always @(posedge ref_clk) begin
        cycles++;
        wdt_osc_tick <= ($random(seed) & 15) == 0;
        // Running tallies; read at an edge they hold all earlier edges
        osc_n <= osc_n + wdt_osc_tick;
        wdt_n <= wdt_n + wdt_tick;
        if (psel && penable && pready && !pwrite && expq.size() > 0) begin
            note = expq.pop_front();
            compare(prdata & note[31:0], note[63:32]);
        end
        if (cycles == 60000) begin
            fail_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(TCP_OFS_OPTION, {24'h0, TCP_OPTION_RST}, '1);
        rd(TCP_OFS_COUNT, {24'h0, TCP_COUNT_RST}, '1);
        rd(TCP_OFS_CTRL, 32'h0, '1);
        apb(1'b1, TCP_OFS_OPTION, 32'h08);
        v = $random(seed);
        apb(1'b1, TCP_OFS_COUNT, {24'h0, v});
        repeat (3) rd(TCP_OFS_COUNT, {24'h0, v}, '1);
        // Eight ticks per window at every ratio; the two blocked cycles cost two of them at 1:1, one above
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, TCP_OFS_OPTION, i < 8 ? i : 32'h08);
            apb(1'b1, TCP_OFS_COUNT, 32'h0B);
            idle(32 * (i < 8 ? 2 << i : 1));
            rd(TCP_OFS_COUNT, 32'h10, 32'hFC);
        end
        // Odd toggle count gives one more edge of the chosen kind
        for (int e = 0; e < 2; e++) begin
            apb(1'b1, TCP_OFS_OPTION, e ? 32'h38 : 32'h28);
            apb(1'b1, TCP_OFS_COUNT, 32'h40);
            idle(1);
            tcp_pin_model_i.toggle(7);
            idle(4);
            rd(TCP_OFS_COUNT, 32'h44, '1);
        end
        // Watchdog ticks: code 010 divides by four, timer-owned passes all
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, TCP_OFS_OPTION, k ? 32'h00 : 32'h0A);
            idle(1);
            o0 = osc_n;
            idle(1);
            w0 = wdt_n;
            idle(400);
            o0 = osc_n - o0;
            idle(1);
            compare(wdt_n - w0, k ? o0 : o0 / 4);
        end
        apb(1'b1, TCP_OFS_OPTION, 32'h08);
        apb(1'b1, TCP_OFS_COUNT, 32'hFD);
        idle(40);
        rd(TCP_OFS_STATUS, 32'h1, 32'h1);
        chk_irq(1'b0);
        apb(1'b1, TCP_OFS_MASK, 32'h1);
        idle(3);
        chk_irq(1'b1);
        apb(1'b1, TCP_OFS_MASK, 32'h0);
        idle(2);
        chk_irq(1'b0);
        apb(1'b1, TCP_OFS_MASK, 32'h1);
        apb(1'b1, TCP_OFS_STATUS, 32'h1);
        idle(3);
        chk_irq(1'b0);
        rd(TCP_OFS_STATUS, 32'h0, 32'h1);
        sleep <= 1'b1;
        apb(1'b1, TCP_OFS_COUNT, 32'h77);
        idle(40);
        repeat (2) rd(TCP_OFS_COUNT, 32'h77, '1);
        sleep <= 1'b0;
        idle(2);
        finish_test();
    end
endmodule
